/* File: verilog/irq_flags_consts.vh */
`ifndef IRQ_FLAGS_CONSTS_VH
`define IRQ_FLAGS_CONSTS_VH

// Register bus geometry
`define APB_ADDR_W 12
`define APB_DATA_W 32
`define FLAG_W 8

// Register byte offsets, one aligned word each
`define OFF_FLAGS 12'h000
`define OFF_ENABLE 12'h004
`define OFF_CLEAR 12'h008
`define OFF_PENDING 12'h00c
`define OFF_OVERRUN 12'h010

// Flag positions inside the flag word
`define BIT_TIMER6 7
`define BIT_COMP2 6
`define BIT_COMP1 5
`define BIT_NVM_DONE 4
`define BIT_SERIAL2_DONE 3
`define BIT_SERIAL2_COLL 2
`define BIT_TIMER4 1
`define BIT_OSC_ROLL 0

// Reset values
`define RST_FLAGS 8'h00
`define RST_ENABLE 8'h00
`define RST_OVERRUN 8'h00
`define RST_RDATA 32'h0000_0000

// Read filler above the flag byte
`define RD_PAD 24'h00_0000
`define ZERO_FLAGS 8'h00

`endif

/* File: verilog/flag_cell.v */
`timescale 1ns/100ps

// One hardware-set, software-cleared flag with an overrun marker
module flag_cell (
    pclk,
    presetn,
    set_evt,
    sw_wr,
    sw_val,
    sw_clr,
    flag_q,
    overrun_q
);
    input wire pclk;
    input wire presetn;
    input wire set_evt;
    input wire sw_wr;
    input wire sw_val;
    input wire sw_clr;
    output reg flag_q;
    output reg overrun_q;

    wire clearing;
    wire keep;
    wire flag_d;
    wire overrun_d;

    // Software drops the flag by writing zero or by the clear register
    assign clearing = sw_clr | (sw_wr & ~sw_val);
    // Direct write may also set the flag, as on a plain R/W bit
    assign keep = sw_wr ? sw_val : (flag_q & ~sw_clr);
    // Event in the clearing cycle wins, so no request is lost
    assign flag_d = set_evt | keep;
    // Second event on a pending flag is remembered until the clear
    assign overrun_d = (set_evt & flag_q & ~clearing) |
                       (overrun_q & ~clearing);

    // State clears on every reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            overrun_q <= overrun_d;
        end
    end
endmodule

/* File: verilog/peripheral_irq_flag_reg_1.v */
`timescale 1ns/100ps
`include "irq_flags_consts.vh"

module peripheral_irq_flag_reg_1 (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    pstrb,
    prdata,
    pready,
    pslverr,
    timer6_match,
    comparator2_irq,
    comparator1_irq,
    nvm_task_done,
    serial2_done,
    serial2_collision,
    timer4_match,
    osc_rollover,
    peripheral_irq_flags_1,
    irq
);
    input wire pclk;
    input wire presetn;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [`APB_ADDR_W-1:0] paddr;
    input wire [`APB_DATA_W-1:0] pwdata;
    input wire [3:0] pstrb;
    output reg [`APB_DATA_W-1:0] prdata;
    output wire pready;
    output reg pslverr;
    input wire timer6_match;
    input wire comparator2_irq;
    input wire comparator1_irq;
    input wire nvm_task_done;
    input wire serial2_done;
    input wire serial2_collision;
    input wire timer4_match;
    input wire osc_rollover;
    output wire [`FLAG_W-1:0] peripheral_irq_flags_1;
    output wire irq;

    // Source conditions gathered into flag order
    wire [`FLAG_W-1:0] src_evt;
    // Flag and overrun state from the cells
    wire [`FLAG_W-1:0] flag_vec;
    wire [`FLAG_W-1:0] overrun_vec;
    // Enable register
    reg [`FLAG_W-1:0] enable_q;
    reg [`FLAG_W-1:0] enable_d;
    // Bus phase decode
    wire setup_ph;
    wire access_ph;
    wire wr_acc;
    wire rd_setup;
    // Address decode
    wire hit_flags;
    wire hit_enable;
    wire hit_clear;
    wire hit_pending;
    wire hit_overrun;
    wire hit_any;
    wire hit_ro;
    // Per-bit software strobes into the cells
    wire flags_wr;
    wire clear_wr;
    wire [`FLAG_W-1:0] sw_clr_vec;
    wire [`FLAG_W-1:0] pending_vec;
    // Read mux and error result
    reg [`APB_DATA_W-1:0] rdata_d;
    reg slverr_d;

    // Sources come from logic on pclk, so no synchroniser is needed
    // A source held high re-sets its flag each cycle, so clears wait
    assign src_evt[`BIT_TIMER6] = timer6_match;
    assign src_evt[`BIT_COMP2] = comparator2_irq;
    assign src_evt[`BIT_COMP1] = comparator1_irq;
    assign src_evt[`BIT_NVM_DONE] = nvm_task_done;
    assign src_evt[`BIT_SERIAL2_DONE] = serial2_done;
    assign src_evt[`BIT_SERIAL2_COLL] = serial2_collision;
    assign src_evt[`BIT_TIMER4] = timer4_match;
    assign src_evt[`BIT_OSC_ROLL] = osc_rollover;

    // Zero wait states: every access completes in one access cycle
    // A slower register file would have to pull this low instead
    assign pready = 1'b1;

    // Phase decode of the APB handshake
    // Reads are fetched in setup so prdata can leave a flop
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_acc = access_ph & pwrite;
    assign rd_setup = setup_ph & ~pwrite;

    // Full address compare, so misaligned addresses fall to unmapped
    // Offsets live in the header so bench and logic share them
    assign hit_flags = (paddr == `OFF_FLAGS);
    assign hit_enable = (paddr == `OFF_ENABLE);
    assign hit_clear = (paddr == `OFF_CLEAR);
    assign hit_pending = (paddr == `OFF_PENDING);
    assign hit_overrun = (paddr == `OFF_OVERRUN);
    assign hit_any = hit_flags | hit_enable | hit_clear |
                     hit_pending | hit_overrun;
    assign hit_ro = hit_pending | hit_overrun;

    // Only byte lane 0 carries flag bits; other lanes are ignored
    // A clear-register write never sets a flag, whatever the data
    assign flags_wr = wr_acc & hit_flags & pstrb[0];
    assign clear_wr = wr_acc & hit_clear & pstrb[0];
    assign sw_clr_vec = clear_wr ? pwdata[`FLAG_W-1:0] : `ZERO_FLAGS;

    // Flags are set by hardware or by a flag-word write; enables never gate them
    // One cell per flag, named after its source to ease debug
    // All cells share the write strobe; each takes its own data bit

    // Bit 7: timer six count reached its period
    // Stays set until software writes zero or clears it
    flag_cell u_timer6_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(src_evt[`BIT_TIMER6]),
        .sw_wr(flags_wr),
        .sw_val(pwdata[`BIT_TIMER6]),
        .sw_clr(sw_clr_vec[`BIT_TIMER6]),
        .flag_q(flag_vec[`BIT_TIMER6]),
        .overrun_q(overrun_vec[`BIT_TIMER6])
    );

    // Bit 6: second comparator interrupt
    // The comparator output itself is not kept, only the request
    flag_cell u_comp2_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(src_evt[`BIT_COMP2]),
        .sw_wr(flags_wr),
        .sw_val(pwdata[`BIT_COMP2]),
        .sw_clr(sw_clr_vec[`BIT_COMP2]),
        .flag_q(flag_vec[`BIT_COMP2]),
        .overrun_q(overrun_vec[`BIT_COMP2])
    );

    // Bit 5: first comparator interrupt
    // Reads zero until the comparator asserts its request or software writes a one
    flag_cell u_comp1_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(src_evt[`BIT_COMP1]),
        .sw_wr(flags_wr),
        .sw_val(pwdata[`BIT_COMP1]),
        .sw_clr(sw_clr_vec[`BIT_COMP1]),
        .flag_q(flag_vec[`BIT_COMP1]),
        .overrun_q(overrun_vec[`BIT_COMP1])
    );

    // Bit 4: non-volatile memory programming task finished
    // A long task ends with one pulse; the flag keeps it
    flag_cell u_nvm_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(src_evt[`BIT_NVM_DONE]),
        .sw_wr(flags_wr),
        .sw_val(pwdata[`BIT_NVM_DONE]),
        .sw_clr(sw_clr_vec[`BIT_NVM_DONE]),
        .flag_q(flag_vec[`BIT_NVM_DONE]),
        .overrun_q(overrun_vec[`BIT_NVM_DONE])
    );

    // Bit 3: second serial port finished a transfer or bus condition
    // Zero while the port is still busy with it
    flag_cell u_ser2_done_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(src_evt[`BIT_SERIAL2_DONE]),
        .sw_wr(flags_wr),
        .sw_val(pwdata[`BIT_SERIAL2_DONE]),
        .sw_clr(sw_clr_vec[`BIT_SERIAL2_DONE]),
        .flag_q(flag_vec[`BIT_SERIAL2_DONE]),
        .overrun_q(overrun_vec[`BIT_SERIAL2_DONE])
    );

    // Bit 2: second serial port saw a bus collision
    // A second collision before the clear shows as an overrun
    flag_cell u_ser2_coll_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(src_evt[`BIT_SERIAL2_COLL]),
        .sw_wr(flags_wr),
        .sw_val(pwdata[`BIT_SERIAL2_COLL]),
        .sw_clr(sw_clr_vec[`BIT_SERIAL2_COLL]),
        .flag_q(flag_vec[`BIT_SERIAL2_COLL]),
        .overrun_q(overrun_vec[`BIT_SERIAL2_COLL])
    );

    // Bit 1: timer four count reached its period
    // Periodic source, so a slow handler will see overruns
    flag_cell u_timer4_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(src_evt[`BIT_TIMER4]),
        .sw_wr(flags_wr),
        .sw_val(pwdata[`BIT_TIMER4]),
        .sw_clr(sw_clr_vec[`BIT_TIMER4]),
        .flag_q(flag_vec[`BIT_TIMER4]),
        .overrun_q(overrun_vec[`BIT_TIMER4])
    );

    // Bit 0: oscillator accumulator rolled over
    // Fast rollovers merge into one request between clears
    flag_cell u_osc_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(src_evt[`BIT_OSC_ROLL]),
        .sw_wr(flags_wr),
        .sw_val(pwdata[`BIT_OSC_ROLL]),
        .sw_clr(sw_clr_vec[`BIT_OSC_ROLL]),
        .flag_q(flag_vec[`BIT_OSC_ROLL]),
        .overrun_q(overrun_vec[`BIT_OSC_ROLL])
    );

    // Raw flags are visible as a level for the core's own polling
    // Polling here costs no bus cycle and has no side effect
    assign peripheral_irq_flags_1 = flag_vec;

    // Masked view; stale flags show here once enabled, hence clear first
    // Enables only mask the output; the flags beneath keep latching
    assign pending_vec = flag_vec & enable_q;
    assign irq = |pending_vec;

    // Enable register next value
    // Lane 0 off leaves the enables as they were
    always @* begin
        enable_d = enable_q;
        if (wr_acc && hit_enable && pstrb[0]) begin
            enable_d = pwdata[`FLAG_W-1:0];
        end
    end

    // Enable register, cleared on reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= `RST_ENABLE;
        end else begin
            enable_q <= enable_d;
        end
    end

    // Read mux; the clear register is write-only and reads zero
    // Unmapped addresses fall through to zero as well
    always @* begin
        rdata_d = `RST_RDATA;
        if (hit_flags) begin
            rdata_d = {`RD_PAD, flag_vec};
        end else if (hit_enable) begin
            rdata_d = {`RD_PAD, enable_q};
        end else if (hit_pending) begin
            rdata_d = {`RD_PAD, pending_vec};
        end else if (hit_overrun) begin
            rdata_d = {`RD_PAD, overrun_vec};
        end
    end

    // Error on unmapped addresses and on writes to read-only words
    // Flag and enable writes never error, even with lane 0 off
    always @* begin
        slverr_d = 1'b0;
        if (!hit_any) begin
            slverr_d = 1'b1;
        end else if (pwrite && hit_ro) begin
            slverr_d = 1'b1;
        end
    end

    // Read data captured in setup, so it is a flop during access
    // An event landing in the access cycle shows on the next read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `RST_RDATA;
        end else if (rd_setup) begin
            prdata <= rdata_d;
        end else if (setup_ph) begin
            prdata <= `RST_RDATA;
        end
    end

    // Error flag also registered at setup; held through the first idle cycle, cleared at the first edge with psel low
    // Dropping it once psel is low keeps idle cycles after the first free of stale errors
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= slverr_d;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end
endmodule

/* File: verif/irq_src_model.sv */
`timescale 1ns/100ps

// Peripheral side: condition pulses launched just after an edge
module irq_src_model (
    input wire pclk,
    input wire presetn,
    input wire [7:0] req,
    output reg [7:0] src
);
    // Registered, so a request becomes a clean one-cycle pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src <= 8'h00;
        end else begin
            src <= req;
        end
    end
endmodule

/* File: verif/peripheral_irq_flag_reg_1_checker.sv */
`timescale 1ns/100ps
`include "irq_flags_consts.vh"

// Flag register behaviour seen from the top ports
module peripheral_irq_flag_reg_1_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire timer6_match,
    input wire comparator2_irq,
    input wire comparator1_irq,
    input wire nvm_task_done,
    input wire serial2_done,
    input wire serial2_collision,
    input wire timer4_match,
    input wire osc_rollover,
    input wire [`FLAG_W-1:0] peripheral_irq_flags_1
);
    // Strobe ignored: a superset of writes keeps these safe
    wire [7:0] f = peripheral_irq_flags_1;
    wire [7:0] s = {timer6_match, comparator2_irq, comparator1_irq,
        nvm_task_done, serial2_done, serial2_collision, timer4_match,
        osc_rollover};
    wire sw = psel & penable & pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_SET: assert property (s != 8'h00 |=>
        (f & $past(s)) == $past(s)) else $error("flag not set");
    AST_HOLD: assert property (($past(f) & ~f) != 8'h00 |->
        $past(sw)) else $error("flag fell alone");
    AST_COMP1: assert property ($rose(f[5]) |->
        $past(comparator1_irq) || $past(sw)) else $error("bit5 bad");
    AST_SER_DONE: assert property ($rose(f[3]) |->
        $past(serial2_done) || $past(sw)) else $error("bit3 bad");
    AST_SER_COLL: assert property (!serial2_collision && !sw && !f[2]
        |=> !f[2]) else $error("bit2 bad");
    AST_TIMER4: assert property (timer4_match |=> f[1])
        else $error("bit1 bad");
    AST_RST: assert property (disable iff (1'b0)
        !presetn |-> f == 8'h00) else $error("reset value bad");
    cover property (s == 8'hff);
    cover property (sw ##1 f == 8'h00);
    cover property ($fell(f[2]));
endmodule

bind peripheral_irq_flag_reg_1 peripheral_irq_flag_reg_1_checker chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .timer6_match,
    .comparator2_irq, .comparator1_irq, .nvm_task_done, .serial2_done,
    .serial2_collision, .timer4_match, .osc_rollover,
    .peripheral_irq_flags_1);

/* File: verif/peripheral_irq_flag_reg_1_test.sv */
`timescale 1ns/100ps
`include "irq_flags_consts.vh"

module peripheral_irq_flag_reg_1_test;
    reg pclk, presetn, psel, penable, pwrite, er;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    reg [7:0] req;
    reg [3:0] pstrb;
    wire [7:0] s, flags;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    integer err_total, cmp_count, seed, i, ef, en, w, eo;

    peripheral_irq_flag_reg_1 uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer6_match(s[7]), .comparator2_irq(s[6]),
        .comparator1_irq(s[5]), .nvm_task_done(s[4]), .serial2_done(s[3]),
        .serial2_collision(s[2]), .timer4_match(s[1]), .osc_rollover(s[0]),
        .peripheral_irq_flags_1(flags), .irq(irq));
    irq_src_model srcs (.pclk(pclk), .presetn(presetn), .req(req), .src(s));

    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #40000;
        err_total = err_total + 1;
        report_and_stop;
    end

    task check(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: %h not %h", $time, seen, exp);
            end
        end
    endtask

    // One APB transfer; waits on pready, only the watchdog ends a hang
    task apb(input w_, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w_;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // Source pulse; the model then expects those flags set
    task fire(input [7:0] v);
        begin
            req <= v;
            @(posedge pclk);
            req <= 8'h00;
            repeat (2) @(posedge pclk);
            eo = eo | (ef & v);
            ef = ef | v;
        end
    endtask

    task report_and_stop;
        begin
            $display("compares %0d errors %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask

    initial begin
        err_total = 0;
        cmp_count = 0;
        ef = 0;
        eo = 0;
        en = 0;
        seed = 59876;
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0000_0000;
        pstrb <= 4'hf;
        req <= 8'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `OFF_FLAGS, 0);
        check(rd, 0);
        check(er, 0);
        // Each source sets only its own bit, which then waits for software
        for (i = 0; i < 8; i = i + 1) begin
            fire(8'h01 << i);
            repeat (4) @(posedge pclk);
            apb(0, `OFF_FLAGS, 0);
            check(rd, 32'h1 << i);
            check(rd, ef);
            apb(1, `OFF_FLAGS, 0);
            ef = 0;
            eo = 0;
            check(flags, 0);
        end
        // Stale flag while disabled; second event marks an overrun
        fire(8'h20);
        check(irq, 0);
        check(flags, ef);
        fire(8'h20);
        apb(0, `OFF_OVERRUN, 0);
        check(rd, eo);
        // Lane 0 off is ignored; read-only write errors; clear reads 0
        pstrb <= 4'he;
        apb(1, `OFF_FLAGS, 32'hff);
        pstrb <= 4'hf;
        check(er, 0);
        check(flags, ef);
        apb(1, `OFF_PENDING, 32'hff);
        check(er, 1);
        apb(0, `OFF_CLEAR, 0);
        check(rd, 0);
        check(er, 0);
        // Software clears the stale flag before enabling its source
        apb(1, `OFF_CLEAR, 32'h20);
        ef = ef & ~32'h20;
        eo = eo & ~32'h20;
        apb(1, `OFF_ENABLE, 32'h20);
        en = 32'h20;
        check(irq, 0);
        apb(0, `OFF_OVERRUN, 0);
        check(rd, eo);
        fire(8'h20);
        check(irq, 1);
        apb(1, `OFF_FLAGS, 0);
        ef = 0;
        eo = 0;
        check(flags, 0);
        // Random events against clears and enables
        for (i = 0; i < 30; i = i + 1) begin
            w = $random(seed);
            fire(w[7:0]);
            apb(1, `OFF_CLEAR, w >> 8);
            apb(1, `OFF_ENABLE, w >> 16);
            ef = ef & ~(w >> 8);
            eo = eo & ~(w >> 8);
            en = (w >> 16) & 255;
            apb(0, `OFF_PENDING, 0);
            check(rd, ef & en);
            check(irq, (ef & en) != 0);
            check(flags, ef);
            apb(0, `OFF_OVERRUN, 0);
            check(rd, eo);
            apb(0, `OFF_ENABLE, 0);
            check(rd, en);
        end
        // Unmapped and misaligned reads error; the unmapped read returns zero
        apb(0, 12'h014, 0);
        check(er, 1);
        check(rd, 0);
        apb(0, 12'h002, 0);
        check(er, 1);
        // A reset mid-run clears all flags and enables
        fire(8'hff);
        check(flags, 8'hff);
        presetn <= 1'b0;
        @(posedge pclk);
        check(flags, 0);
        presetn <= 1'b1;
        ef = 0;
        eo = 0;
        en = 0;
        @(posedge pclk);
        check(flags, 0);
        apb(0, `OFF_ENABLE, 0);
        check(rd, en);
        check(irq, 0);
        report_and_stop;
    end
endmodule
